// ### src/spi3_device.sv
// Behaviour
// - Transfers are master-started, whole bytes only
// - Select high: pin released, interface ignored
// - Incoming bits sampled on rising clock
// - Read data changes on edge chosen by polarity
// - Select low enables port, pin as input
// - Direction bit then seven address bits
// - Address and data travel LSB first
// - After command, read byte shifted out
// - Master ends only on byte boundaries
// - Block read increments address each byte
// - Write stores byte after eighth bit
// - Multi-byte write increments address
// - Master never writes addresses 0x78 upward
// - Divider sync restarts dividers, self-clears
// - Outputs held low during divider sync
// - Pll_request_a and calibrate bits self-clear
// - Clearing force bit releases VCXO voltage
// - Outputs enabled in separate later write
// - Internal source: pulses per run trigger
// - External source: pulses at next input edge
// - Pulse count mode chosen before trigger
// - Latched flags stick until written one
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module spi3_device import spi3_pkg::*; (
	input  wire logic       clk,                 // System clock
	input  wire logic       nrst,                // Sync reset, active low
	spi3_if.device          link,                // Serial pins
	input  wire logic [7:0] statusCond,          // Live fault conditions
	input  wire logic       externalSysrefInput, // External pulse trigger
	output logic      [7:0] clockOutputs,        // Clock output enables
	output logic      [7:0] sysrefOutputs,       // Pulse outputs
	output logic            dividerSyncBusy,     // Divider restart running
	output logic            pllRelockPulse,      // One-cycle pll_request_a request
	output logic            vcoCalPulse,         // One-cycle calibration
	output logic            vcxoVoltageForce     // Control voltage forced
);

	// ********************************
	// Serial front end
	// ********************************
	logic [7:0] regs [REG_COUNT];
	logic       sclkPrev;
	logic [2:0] bitCnt;
	logic       cmdDone;
	logic       isRead;
	logic [6:0] addr;
	logic [7:0] shiftIn;
	logic [7:0] outShift;
	logic [7:0] inByte;
	logic       sclkRise;
	logic       sclkFall;
	logic       byteEnd;
	logic       wrStrobe;
	logic       readLoad;
	logic [6:0] loadAddr;
	logic       readPol;

	// Select high masks every edge
	assign sclkRise = ~link.chipSelectN & link.sclk & ~sclkPrev;
	assign sclkFall = ~link.chipSelectN & ~link.sclk & sclkPrev;
	assign inByte   = {link.serialDataIo, shiftIn[7:1]};
	assign byteEnd  = sclkRise & (bitCnt == 3'd7);
	assign wrStrobe = byteEnd & cmdDone & ~isRead;
	assign readLoad = byteEnd & (cmdDone ? isRead : inByte[0]);
	assign loadAddr = cmdDone ? addr + 7'd1 : inByte[7:1];
	assign readPol  = regs[ADDR_GEN_CTRL][GC_READ_POL];

	// Edge history of the serial clock
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sclkPrev <= 1'b0;
		end else begin
			sclkPrev <= link.sclk;
		end
	end

	// Bit counter, command decode, address pointer
	always_ff @(posedge clk) begin
		if (!nrst || link.chipSelectN) begin
			bitCnt  <= 3'd0;
			cmdDone <= 1'b0;
			isRead  <= 1'b0;
			addr    <= 7'd0;
			shiftIn <= 8'h00;
		end else if (sclkRise) begin
			bitCnt  <= bitCnt + 3'd1;
			shiftIn <= inByte;
			if (bitCnt == 3'd7) begin
				if (!cmdDone) begin
					cmdDone <= 1'b1;
					isRead  <= inByte[0];
					addr    <= inByte[7:1];
				end else begin
					addr <= addr + 7'd1;
				end
			end
		end
	end

	// Read shifter; pin stays input until a read command ends
	always_ff @(posedge clk) begin
		if (!nrst || link.chipSelectN) begin
			link.devOe   <= 1'b0;
			link.devData <= 1'b0;
			outShift     <= 8'h00;
		end else if (readLoad) begin
			link.devOe <= 1'b1;
			if (readPol) begin
				link.devData <= regs[loadAddr][0];
				outShift     <= {1'b0, regs[loadAddr][7:1]};
			end else begin
				outShift <= regs[loadAddr];
			end
		end else if (link.devOe && (readPol ? sclkRise : sclkFall)) begin
			link.devData <= outShift[0];
			outShift     <= {1'b0, outShift[7:1]};
		end
	end

	// ********************************
	// Register file and self-clearing bits
	// ********************************
	logic       syncStart;
	logic       syncDone;
	logic       burstStart;
	logic [7:0] statusClear;

	assign statusClear = (wrStrobe && addr == ADDR_STATUS_LAT) ? inByte : 8'h00;

	// Hardware clears first; a write in the same cycle overrides them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= 8'h00;
			end
			regs[ADDR_GEN_CTRL] <= GEN_CTRL_RESET;
		end else begin
			if (syncDone) begin
				regs[ADDR_GEN_CTRL][GC_DIV_SYNC] <= 1'b0;
			end
			regs[ADDR_GEN_CTRL][GC_PLL_PLL_REQUEST_A] <= 1'b0;
			regs[ADDR_GEN_CTRL][GC_VCO_CAL]    <= 1'b0;
			if (burstStart) begin
				regs[ADDR_RUN][RUN_TRIGGER] <= 1'b0;
			end
			if (wrStrobe && addr != ADDR_STATUS_LAT) begin
				regs[addr] <= inByte;
			end
			// Condition still present sets the flag again; set wins
			regs[ADDR_STATUS_LAT] <= (regs[ADDR_STATUS_LAT] & ~statusClear)
				| statusCond;
		end
	end

	// ********************************
	// Divider sync and PLL controls
	// ********************************
	logic [$clog2(SYNC_CYCLES+1)-1:0] syncCnt;
	logic                             syncActive;

	assign syncStart  = regs[ADDR_GEN_CTRL][GC_DIV_SYNC] & ~dividerSyncBusy;
	assign syncDone   = dividerSyncBusy &&
		(syncCnt == ($clog2(SYNC_CYCLES+1))'(SYNC_CYCLES - 1));
	assign syncActive = regs[ADDR_GEN_CTRL][GC_DIV_SYNC] | dividerSyncBusy;

	// Restart window for all dividers and delays
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dividerSyncBusy <= 1'b0;
			syncCnt         <= '0;
		end else if (syncStart) begin
			dividerSyncBusy <= 1'b1;
			syncCnt         <= '0;
		end else if (syncDone) begin
			dividerSyncBusy <= 1'b0;
		end else if (dividerSyncBusy) begin
			syncCnt <= syncCnt + 1'b1;
		end
	end

	// Request strobes last one cycle because their bits self-clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pllRelockPulse   <= 1'b0;
			vcoCalPulse      <= 1'b0;
			vcxoVoltageForce <= 1'b1;
		end else begin
			pllRelockPulse   <= regs[ADDR_GEN_CTRL][GC_PLL_PLL_REQUEST_A];
			vcoCalPulse      <= regs[ADDR_GEN_CTRL][GC_VCO_CAL];
			vcxoVoltageForce <= regs[ADDR_GEN_CTRL][GC_VCXO_FORCE];
		end
	end

	// ********************************
	// Pulse generator
	// ********************************
	logic                          extPrev;
	logic                          extRise;
	logic                          burstActive;
	logic                          continuous;
	logic [7:0]                    pulsesLeft;
	logic [$clog2(PULSE_HALF)-1:0] phaseCnt;
	logic                          wave;

	assign extRise    = externalSysrefInput & ~extPrev;
	assign burstStart = regs[ADDR_RUN][RUN_TRIGGER] & ~syncActive
		& (regs[ADDR_SYSREF_CTRL][SR_SOURCE_SEL] ? extRise : 1'b1);

	// External trigger edge history
	always_ff @(posedge clk) begin
		if (!nrst) begin
			extPrev <= 1'b0;
		end else begin
			extPrev <= externalSysrefInput;
		end
	end

	// Counted burst or free running; a count of zero gives one pulse
	always_ff @(posedge clk) begin
		if (!nrst || syncActive) begin
			burstActive <= 1'b0;
			continuous  <= 1'b0;
			pulsesLeft  <= 8'h00;
			phaseCnt    <= '0;
			wave        <= 1'b0;
		end else if (burstStart) begin
			burstActive <= 1'b1;
			continuous  <= regs[ADDR_SYSREF_CTRL][SR_COUNT_MODE];
			pulsesLeft  <= regs[ADDR_PULSE_COUNT];
			phaseCnt    <= '0;
			wave        <= 1'b0;
		end else if (burstActive) begin
			if (phaseCnt == ($clog2(PULSE_HALF))'(PULSE_HALF - 1)) begin
				phaseCnt <= '0;
				wave     <= ~wave;
				if (wave && !continuous) begin
					pulsesLeft <= pulsesLeft - 8'h01;
					if (pulsesLeft <= 8'h01) begin
						burstActive <= 1'b0;
					end
				end
			end else begin
				phaseCnt <= phaseCnt + 1'b1;
			end
		end
	end

	// Output stage; held low while dividers restart
	always_ff @(posedge clk) begin
		if (!nrst || syncActive) begin
			clockOutputs  <= 8'h00;
			sysrefOutputs <= 8'h00;
		end else begin
			clockOutputs  <= regs[ADDR_CLK_ENABLE];
			sysrefOutputs <= regs[ADDR_REF_ENABLE] & {8{wave & burstActive}};
		end
	end

endmodule
`default_nettype wire

// ### src/spi3_host.sv
`timescale 1ns/1ps
`default_nettype none
module spi3_host import spi3_pkg::*; #(
	parameter int HALF_CYCLES = SCLK_HALF_CYCLES // Clocks per serial half period
) (
	input  wire logic        clk,     // System clock
	input  wire logic        nrst,    // Sync reset, active low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB enable
	input  wire logic        pwrite,  // APB direction
	input  wire logic [7:0]  paddr,   // APB address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic      [31:0] prdata,  // APB read data
	output logic             pready,  // APB ready
	output logic             pslverr, // APB error
	spi3_if.host             link     // Serial pins
);

	// ********************************
	// APB slave
	// ********************************
	host_state_t state;
	logic [6:0]  devAddr;
	logic        rd;
	logic        pol;
	logic [1:0]  countM1;
	logic [31:0] txWord;
	logic [31:0] rxWord;
	logic        wrAccess;
	logic        startReq;

	assign wrAccess = psel & penable & pready & pwrite;
	assign startReq = wrAccess && paddr == HOST_CTRL && pwdata[0] && state == H_IDLE;

	// Answer prepared in setup, shown in the single access cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > HOST_STATUS || paddr[1:0] != 2'h0);
			unique case (paddr)
				HOST_CTRL:   prdata <= {17'h0, devAddr, 2'h0, countM1, 1'b0, pol, rd, 1'b0};
				HOST_TXDATA: prdata <= txWord;
				HOST_RXDATA: prdata <= rxWord;
				HOST_STATUS: prdata <= {31'h0, state == H_XFER};
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Command fields; locked while a transfer runs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			devAddr <= 7'h00;
			rd      <= 1'b0;
			pol     <= 1'b0;
			countM1 <= 2'h0;
			txWord  <= 32'h0000_0000;
		end else if (wrAccess && state == H_IDLE) begin
			if (paddr == HOST_CTRL) begin
				rd      <= pwdata[1];
				pol     <= pwdata[2];
				countM1 <= pwdata[5:4];
				devAddr <= pwdata[14:8];
			end
			if (paddr == HOST_TXDATA) begin
				txWord <= pwdata;
			end
		end
	end

	// ********************************
	// Serial master
	// ********************************
	logic [$clog2(HALF_CYCLES)-1:0] divCnt;
	logic                           tick;
	logic [5:0]                     bitIdx;
	logic [5:0]                     totalBits;
	logic [39:0]                    seqShift;
	logic [4:0]                     rxIdx;
	logic                           sampleNow;

	assign tick      = state == H_XFER && divCnt == ($clog2(HALF_CYCLES))'(HALF_CYCLES - 1);
	assign totalBits = {{1'b0, countM1} + 3'd2, 3'b000};
	assign rxIdx     = 5'(bitIdx - 6'd8);
	assign sampleNow = tick && rd && (link.sclk ? pol : ~pol)
		&& bitIdx >= 6'd8 && bitIdx < totalBits;

	// Pin sequencer; select falls with the first bit already driven
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state            <= H_IDLE;
			divCnt           <= '0;
			bitIdx           <= 6'd0;
			seqShift         <= 40'h0;
			link.sclk        <= 1'b0;
			link.chipSelectN <= 1'b1;
			link.hostData    <= 1'b0;
			link.hostOe      <= 1'b0;
		end else if (startReq) begin
			state            <= H_XFER;
			divCnt           <= '0;
			bitIdx           <= 6'd0;
			link.chipSelectN <= 1'b0;
			link.hostOe      <= 1'b1;
			link.hostData    <= pwdata[1];
			seqShift         <= {1'b0, txWord, pwdata[14:8]};
		end else if (state == H_XFER) begin
			divCnt <= tick ? '0 : divCnt + 1'b1;
			if (tick && !link.sclk) begin
				link.sclk <= 1'b1;
				bitIdx    <= bitIdx + 6'd1;
				if (rd && bitIdx == 6'd7) begin
					link.hostOe <= 1'b0;
				end
			end else if (tick) begin
				link.sclk <= 1'b0;
				if (bitIdx == totalBits) begin
					state            <= H_IDLE;
					link.chipSelectN <= 1'b1;
					link.hostOe      <= 1'b0;
				end else if (!rd || bitIdx < 6'd8) begin
					link.hostData <= seqShift[0];
					seqShift      <= {1'b0, seqShift[39:1]};
				end
			end
		end
	end

	// Read capture, LSB first, on the edge opposite the device's change
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rxWord <= 32'h0000_0000;
		end else if (sampleNow) begin
			rxWord[rxIdx] <= link.serialDataIo;
		end
	end

endmodule
`default_nettype wire

// ### src/spi3_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spi3_if;
	logic sclk;         // Serial clock from master
	logic chipSelectN;  // Select, active low
	logic hostData;     // Master drive value
	logic hostOe;       // Master drive enable
	logic devData;      // Device drive value
	logic devOe;        // Device drive enable
	logic serialDataIo; // Resolved data line

	// Shared line; idles high when nobody drives
	assign serialDataIo = devOe ? devData : (hostOe ? hostData : 1'b1);

	modport device(input sclk, chipSelectN, serialDataIo, output devData, devOe);
	modport host(output sclk, chipSelectN, hostData, hostOe, input serialDataIo);
endinterface
`default_nettype wire

// ### src/spi3_pkg.sv
package spi3_pkg;

	// ********************************
	// Device register space
	// ********************************
	localparam int         REG_COUNT        = 128;
	localparam logic [6:0] ADDR_PULSE_COUNT = 7'h1A;
	localparam logic [6:0] ADDR_SYSREF_CTRL = 7'h1C;
	localparam logic [6:0] ADDR_STATUS_LAT  = 7'h6C;
	localparam logic [6:0] ADDR_RUN         = 7'h70;
	localparam logic [6:0] ADDR_GEN_CTRL    = 7'h71;
	localparam logic [6:0] ADDR_CLK_ENABLE  = 7'h74;
	localparam logic [6:0] ADDR_REF_ENABLE  = 7'h76;

	// Field positions
	localparam int GC_DIV_SYNC    = 0;
	localparam int GC_PLL_PLL_REQUEST_A  = 1;
	localparam int GC_VCO_CAL     = 2;
	localparam int GC_VCXO_FORCE  = 3;
	localparam int GC_READ_POL    = 7;
	localparam int RUN_TRIGGER    = 0;
	localparam int SR_SOURCE_SEL  = 0;
	localparam int SR_COUNT_MODE  = 1;

	// Values after reset
	localparam logic [7:0] GEN_CTRL_RESET = 8'h08;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS    = 100;
	localparam int SYNC_TIME_NS     = 1600;
	localparam int SYNC_CYCLES      = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_HALF       = 4;
	localparam int SCLK_HALF_CYCLES = 5;
	localparam int CMD_BITS         = 8;

	// ********************************
	// Controller register map (APB)
	// ********************************
	localparam logic [7:0] HOST_CTRL   = 8'h00;
	localparam logic [7:0] HOST_TXDATA = 8'h04;
	localparam logic [7:0] HOST_RXDATA = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0C;

	typedef enum logic {H_IDLE, H_XFER} host_state_t;

endpackage

// ### testbench/spi3_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spi3_link_assertions (
	input wire logic clk,         // System clock
	input wire logic nrst,        // Sync reset, active low
	input wire logic sclk,        // Serial clock
	input wire logic chipSelectN, // Select, active low
	input wire logic hostData,    // Host drive value
	input wire logic hostOe,      // Host drive enable
	input wire logic devData,     // Device drive value
	input wire logic devOe        // Device drive enable
);
	// ****
	// Frame bit counter
	// ****
	logic [5:0] riseCnt;

	// Rising serial edges seen in the current frame
	always_ff @(posedge clk) begin
		if (!nrst || chipSelectN)
			riseCnt <= 6'h00;
		else if ($rose(sclk))
			riseCnt <= riseCnt + 6'h01;
	end

	// ****
	// Link checks
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// One clock of grace after select rises, then the line must be free
	a_idle_pin_released: assert property (chipSelectN && $past(chipSelectN) |-> !devOe)
		else $error("device drives line while deselected");
	a_drive_in_frame: assert property ($rose(devOe) |-> !chipSelectN)
		else $error("device drive starts outside a frame");
	a_turn_after_cmd: assert property ($rose(devOe) |-> riseCnt == 6'h08)
		else $error("device turns line at wrong bit count");
	a_host_bit_stable: assert property ($rose(sclk) && hostOe |-> $stable(hostData))
		else $error("host data moves at sampling edge");
	// Device data may move only shortly after a serial edge
	a_read_edge_timed: assert property (devOe && $past(devOe) && !chipSelectN && $changed(devData)
		|-> $past(sclk) != $past(sclk, 3))
		else $error("read data changes away from a serial edge");
	a_frame_whole_bytes: assert property ($rose(chipSelectN)
		|-> riseCnt[2:0] == 3'h0 && riseCnt != 6'h00)
		else $error("frame ends off a byte boundary");
	a_select_held: assert property ($fell(chipSelectN) |-> !chipSelectN [*8])
		else $error("select bounces inside a frame");
	a_clock_idle_low: assert property (chipSelectN |-> !sclk)
		else $error("serial clock high between frames");
	a_host_lets_go: assert property (chipSelectN |-> !hostOe)
		else $error("host drives line while deselected");

	c_read_turn: cover property ($rose(devOe));
	c_three_byte: cover property ($rose(chipSelectN) && riseCnt == 6'h20);
	c_read_bit: cover property (devOe && $rose(sclk));
endmodule
`default_nettype wire

// ### testbench/test_three_wire_spi_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_three_wire_spi_config_port import spi3_pkg::*; ();
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, extRef, err;
	logic        syncBusy, relockPulse, calPulse, vcxoForce, prevRef, prevBusy;
	logic [7:0]  paddr, statusCond, clockOutputs, sysrefOutputs;
	logic [31:0] pwdata, prdata, rd;
	int          err_count = 0, compares = 0, n, pulseCnt = 0, relockCnt = 0, calCnt = 0;
	int          busyCnt = 0, leakCnt = 0;

	spi3_if link ();
	spi3_host u_spi3_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	spi3_device u_spi3_device (.clk(clk), .nrst(nrst), .link(link), .statusCond(statusCond),
		.externalSysrefInput(extRef), .clockOutputs(clockOutputs),
		.sysrefOutputs(sysrefOutputs), .dividerSyncBusy(syncBusy),
		.pllRelockPulse(relockPulse), .vcoCalPulse(calPulse), .vcxoVoltageForce(vcxoForce));
	spi3_link_assertions chk_link (.clk(clk), .nrst(nrst), .sclk(link.sclk),
		.chipSelectN(link.chipSelectN), .hostData(link.hostData), .hostOe(link.hostOe),
		.devData(link.devData), .devOe(link.devOe));

	// ****
	// Clock, watchdog, output monitors
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Cuts a hung run short
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	// Counts pulses and sync time; first busy cycle skipped as outputs lag one clock
	always @(posedge clk) begin
		prevRef <= sysrefOutputs[0];
		prevBusy <= syncBusy;
		if (sysrefOutputs[0] === 1'b1 && prevRef === 1'b0)
			pulseCnt <= pulseCnt + 1;
		if (relockPulse === 1'b1)
			relockCnt <= relockCnt + 1;
		if (calPulse === 1'b1)
			calCnt <= calCnt + 1;
		if (syncBusy === 1'b1)
			busyCnt <= busyCnt + 1;
		if (syncBusy === 1'b1 && prevBusy === 1'b1 && (clockOutputs | sysrefOutputs) !== 8'h00)
			leakCnt <= leakCnt + 1;
	end

	// ****
	// Tasks
	// ****
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; ready and data are taken at the sampling edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			err_count++;
			tally_and_finish();
		end
	endtask

	// One serial frame: data first for a write only, then start, then wait for idle
	task automatic xfer(input logic r, input logic p, input logic [1:0] nb, input logic [6:0] a,
		input logic [31:0] tx, output logic [31:0] rx);
		logic        e;
		logic [31:0] s;
		int          k;
		if (!r)
			apb(1'b1, HOST_TXDATA, tx, s, e);
		apb(1'b1, HOST_CTRL, {17'h00000, a, 2'h0, nb, 1'h0, p, r, 1'h1}, s, e);
		k = 0;
		do begin
			apb(1'b0, HOST_STATUS, 32'h0, s, e);
			k++;
		end while (s[0] !== 1'b0 && k < 200);
		if (k >= 200) begin
			err_count++;
			tally_and_finish();
		end
		apb(1'b0, HOST_RXDATA, 32'h0, rx, e);
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		statusCond = 8'h00;
		extRef = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		xfer(1'b1, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h0, rd);
		chk("gen ctrl reset", {24'h0, GEN_CTRL_RESET}, rd & 32'hFF);
		chk("vcxo force reset", 32'h1, {31'h0, vcxoForce});
		// Three bytes from 0x74: auto-increment both ways
		xfer(1'b0, 1'b0, 2'h2, ADDR_CLK_ENABLE, 32'h00FFC35A, rd);
		chk("clock outputs", 32'h5A, {24'h0, clockOutputs});
		xfer(1'b1, 1'b0, 2'h2, ADDR_CLK_ENABLE, 32'h0, rd);
		chk("block read", 32'h00FFC35A, rd & 32'h00FFFFFF);
		// Read with data changing on the rising edge
		xfer(1'b0, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h88, rd);
		xfer(1'b1, 1'b1, 2'h1, ADDR_GEN_CTRL, 32'h0, rd);
		chk("rising edge read", 32'h88, rd & 32'hFF);
		// Divider sync, polarity back to falling edge
		xfer(1'b0, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h09, rd);
		repeat (40) @(posedge clk);
		chk("sync length", SYNC_CYCLES, busyCnt);
		chk("outputs low in sync", 32'h0, leakCnt);
		chk("clock outputs back", 32'h5A, {24'h0, clockOutputs});
		xfer(1'b1, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h0, rd);
		chk("sync self clear", 32'h08, rd & 32'hFF);
		// Pll_request_a and calibrate in their own access, force released
		xfer(1'b0, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h06, rd);
		chk("pll_request_a pulses", 32'h1, relockCnt);
		chk("calibrate pulses", 32'h1, calCnt);
		chk("vcxo released", 32'h0, {31'h0, vcxoForce});
		xfer(1'b1, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h0, rd);
		chk("gen ctrl cleared", 32'h00, rd & 32'hFF);
		// Flag 0 pulses and goes away, flag 1 stays present
		statusCond <= 8'h01;
		repeat (3) @(posedge clk);
		statusCond <= 8'h02;
		xfer(1'b1, 1'b0, 2'h0, ADDR_STATUS_LAT, 32'h0, rd);
		chk("flags latched", 32'h03, rd & 32'hFF);
		xfer(1'b0, 1'b0, 2'h0, ADDR_STATUS_LAT, 32'h03, rd);
		xfer(1'b1, 1'b0, 2'h0, ADDR_STATUS_LAT, 32'h0, rd);
		chk("flags after clear", 32'h02, rd & 32'hFF);
		statusCond <= 8'h00;
		// Internal source, counted burst of two
		xfer(1'b0, 1'b0, 2'h2, ADDR_PULSE_COUNT, 32'h000002, rd);
		n = pulseCnt;
		xfer(1'b0, 1'b0, 2'h0, ADDR_RUN, 32'h01, rd);
		repeat (100) @(posedge clk);
		chk("internal burst", 32'h2, pulseCnt - n);
		xfer(1'b1, 1'b0, 2'h0, ADDR_RUN, 32'h0, rd);
		chk("run trigger cleared", 32'h0, rd & 32'hFF);
		// External source waits for the input edge
		xfer(1'b0, 1'b0, 2'h0, ADDR_SYSREF_CTRL, 32'h01, rd);
		n = pulseCnt;
		xfer(1'b0, 1'b0, 2'h0, ADDR_RUN, 32'h01, rd);
		repeat (100) @(posedge clk);
		chk("no pulse before edge", 32'h0, pulseCnt - n);
		extRef <= 1'b1;
		repeat (100) @(posedge clk);
		chk("external burst", 32'h2, pulseCnt - n);
		extRef <= 1'b0;
		// Continuous pulsing runs until a divider sync stops it
		xfer(1'b0, 1'b0, 2'h0, ADDR_SYSREF_CTRL, 32'h02, rd);
		xfer(1'b0, 1'b0, 2'h0, ADDR_RUN, 32'h01, rd);
		n = pulseCnt;
		repeat (96) @(posedge clk);
		chk("continuous pulses", 32'(96 / (2 * PULSE_HALF)), pulseCnt - n);
		xfer(1'b0, 1'b0, 2'h0, ADDR_GEN_CTRL, 32'h01, rd);
		repeat (40) @(posedge clk);
		n = pulseCnt;
		repeat (100) @(posedge clk);
		chk("pulses stop on sync", 32'h0, pulseCnt - n);
		chk("outputs low in second sync", 32'h0, leakCnt);
		apb(1'b0, 8'h10, 32'h0, rd, err);
		chk("apb slave error", 32'h1, {31'h0, err});
		tally_and_finish();
	end
endmodule
`default_nettype wire
